// *** rtl/spiu_pkg.sv ***
// Package of constants and types for the SCSI processor interrupt unit.
package spiu_pkg;
  localparam int SC_W = 8;
  localparam int DM_W = 7;
  localparam int CLK_NS = 20;
  localparam int GAP_NS = 100;
  localparam int GAP_CYC = (GAP_NS / CLK_NS < 1) ? 1 : GAP_NS / CLK_NS;
  localparam int GAP_W = 4;
  localparam int HOST_BYTE_GAP_CLK = 10;
  localparam logic [7:0] OFS_SCSI_STAT = 8'h00;
  localparam logic [7:0] OFS_DMA_STAT = 8'h04;
  localparam logic [7:0] OFS_BOTH_STAT = 8'h08;
  localparam logic [7:0] OFS_SUMMARY = 8'h0C;
  localparam logic [7:0] OFS_SCSI_EN = 8'h10;
  localparam logic [7:0] OFS_DMA_EN = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam int SC_CMP_BIT = 0;
  localparam int SC_SEL_BIT = 1;
  localparam int SC_ATN_BIT = 2;
  localparam int DMA_DFE_BIT = 7;
  localparam int BOTH_DMA_LSB = 8;
  localparam int SUM_SIP_BIT = 0;
  localparam int SUM_DIP_BIT = 1;
  localparam int SUM_HALT_BIT = 2;
  localparam int SUM_IRQ_BIT = 3;
  localparam int CTL_CLF_BIT = 0;
  localparam int CTL_FLF_BIT = 1;
  localparam logic [SC_W-1:0] SCSI_EN_RST = 8'h00;
  localparam logic [DM_W-1:0] DMA_EN_RST = 7'h00;
  typedef struct packed {
    logic fetch_busy;
    logic fetch_fault;
    logic reqack_busy;
    logic sync_pending;
    logic tc_exec;
    logic jump_on_phase;
    logic to_mem;
    logic fifo_empty;
  } spiu_seq_s;
  typedef enum logic [2:0] {
    HS_RUN = 3'b001,
    HS_DRAIN = 3'b010,
    HS_HALT = 3'b100
  } spiu_halt_e;
endpackage : spiu_pkg

// *** rtl/spiu_stack.sv ***
// Two-level interrupt stack for one interrupt type.
`timescale 1ns/1ps
module spiu_stack #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] post,
  input wire logic [W-1:0] raise,
  input wire logic [W-1:0] en_hit,
  input wire logic any_pend,
  input wire logic rd_clr,
  output logic [W-1:0] status,
  output logic pend,
  output logic irqf,
  output logic stacked
);
  import spiu_pkg::*;
  if (W < 1 || W > 16) begin : g_chk
    $error("spiu_stack width out of range");
  end
  logic [W-1:0] st_ff;
  logic [W-1:0] sh_ff;
  logic pend_ff;
  logic irq_ff;
  logic shp_ff;
  logic shi_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff <= '0;
      sh_ff <= '0;
      pend_ff <= 1'b0;
      irq_ff <= 1'b0;
      shp_ff <= 1'b0;
      shi_ff <= 1'b0;
    end else if (ce) begin
      if (rd_clr) begin
        // Arrivals in the clearing cycle join the moved-in level and are not lost.
        st_ff <= sh_ff | post;
        pend_ff <= shp_ff | (|raise);
        irq_ff <= shi_ff | (|en_hit);
        sh_ff <= '0;
        shp_ff <= 1'b0;
        shi_ff <= 1'b0;
      end else if (any_pend) begin
        sh_ff <= sh_ff | post;
        shp_ff <= shp_ff | (|raise);
        shi_ff <= shi_ff | (|en_hit);
      end else begin
        st_ff <= st_ff | post;
        pend_ff <= pend_ff | (|raise);
        irq_ff <= irq_ff | (|en_hit);
      end
    end
  end
  assign status = st_ff;
  assign pend = pend_ff;
  assign irqf = irq_ff;
  assign stacked = (|sh_ff) | shp_ff;
  chk_stack_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ce && any_pend && !rd_clr |=> st_ff == $past(st_ff))
    else $error("visible status changed while a level was pending");
  chk_stack_merge: assert property (@(posedge clk) disable iff (!rst_b)
    ce && any_pend && !rd_clr |=> (sh_ff & $past(sh_ff | post)) == $past(sh_ff | post))
    else $error("shadow lost a stacked condition");
  chk_move_in: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rd_clr |=> st_ff == $past(sh_ff | post) && sh_ff == '0)
    else $error("stacked conditions did not move in");
endmodule : spiu_stack

// *** rtl/spiu_halt.sv ***
// Orderly halt sequencer for the script engine.
`timescale 1ns/1ps
module spiu_halt (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic cause,
  input wire logic scsi_cause,
  input wire logic release_halt,
  input wire spiu_pkg::spiu_seq_s seq,
  output logic halted,
  output logic inhibit,
  output logic flush_req,
  output logic dsp_load
);
  import spiu_pkg::*;
  spiu_halt_e state_ff;
  spiu_halt_e nxt_state;
  logic scsi_ff;
  logic busy;
  logic want_flush;
  // A faulted fetch is abandoned; other fetches, handshakes, offsets and transfers finish, and the fifo drains only for a scsi cause to memory.
  assign want_flush = scsi_ff && seq.to_mem && !seq.fifo_empty;
  assign busy = (seq.fetch_busy && !seq.fetch_fault) || seq.reqack_busy
    || seq.sync_pending || seq.tc_exec || want_flush;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HS_RUN: begin
        if (cause) begin
          nxt_state = HS_DRAIN;
        end
      end
      HS_DRAIN: begin
        if (!busy) begin
          nxt_state = HS_HALT;
        end
      end
      HS_HALT: begin
        if (release_halt) begin
          nxt_state = HS_RUN;
        end
      end
      default: nxt_state = HS_RUN;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= HS_RUN;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scsi_ff <= 1'b0;
    end else if (ce && state_ff == HS_RUN) begin
      scsi_ff <= scsi_cause;
    end else if (ce) begin
      scsi_ff <= scsi_ff | scsi_cause;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halted <= 1'b0;
      inhibit <= 1'b0;
      flush_req <= 1'b0;
      dsp_load <= 1'b0;
    end else if (ce) begin
      halted <= nxt_state == HS_HALT;
      inhibit <= nxt_state != HS_RUN;
      flush_req <= state_ff == HS_DRAIN && want_flush;
      dsp_load <= state_ff == HS_DRAIN && !busy && seq.jump_on_phase;
    end
  end
  chk_drain_wait: assert property (@(posedge clk) disable iff (!rst_b)
    state_ff == HS_DRAIN && (seq.reqack_busy || seq.sync_pending || seq.tc_exec) |=> state_ff != HS_HALT)
    else $error("halted with a handshake, offset or transfer still open");
  chk_dsp_jump: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state_ff == HS_DRAIN && !busy && seq.jump_on_phase |=> dsp_load && state_ff == HS_HALT)
    else $error("jump target not loaded before halt");
  chk_flush_dir: assert property (@(posedge clk) disable iff (!rst_b)
    flush_req |-> $past(scsi_ff) && $past(seq.to_mem))
    else $error("flush requested without a scsi cause toward memory");
endmodule : spiu_halt

// *** rtl/spiu_top.sv ***
// Interrupt unit top: bus slave, masking, stacking, request line and halt control.
`timescale 1ns/1ps
module spiu_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [spiu_pkg::SC_W-1:0] scsi_cond,
  input wire logic [spiu_pkg::DM_W-1:0] dma_cond,
  input wire logic target_mode,
  input wire spiu_pkg::spiu_seq_s seq,
  output logic irq_n,
  output logic seq_halted,
  output logic exec_inhibit,
  output logic fifo_flush_req,
  output logic dsp_load,
  output logic clear_fifos,
  output logic flush_dma_fifo
);
  import spiu_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction : hit

  function automatic logic [SC_W-1:0] nonfatal_mask(input logic tgt);
    nonfatal_mask = '0;
    nonfatal_mask[SC_CMP_BIT] = 1'b1;
    nonfatal_mask[SC_SEL_BIT] = 1'b1;
    nonfatal_mask[SC_ATN_BIT] = tgt;
  endfunction : nonfatal_mask

  // Bus slave state.
  logic dp_ff;
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic hresp_ff;
  logic accept;
  logic rd_now;
  logic wr_now;

  // Software-visible control.
  logic [SC_W-1:0] scsi_irq_enable_reg_ff;
  logic [DM_W-1:0] dma_irq_enable_reg_ff;
  logic clear_fifos_bit_ff;
  logic flush_dma_fifo_bit_ff;

  // Interrupt path.
  logic [SC_W-1:0] s_hold_ff;
  logic [SC_W-1:0] s_post;
  logic [SC_W-1:0] s_raise;
  logic [SC_W-1:0] s_en;
  logic [DM_W-1:0] d_post;
  logic [DM_W-1:0] d_raise;
  logic [DM_W-1:0] d_en;
  logic [SC_W-1:0] scsi_irq_status_reg;
  logic [DM_W-1:0] dma_irq_status_reg;
  logic scsi_pending_flag;
  logic dma_pending_flag;
  logic s_irqf;
  logic d_irqf;
  logic s_stacked;
  logic d_stacked;
  logic any_pend;
  logic s_clr;
  logic d_clr;
  logic gap_start;
  logic [GAP_W-1:0] gap_cnt_ff;
  logic irq_n_ff;
  logic [7:0] dma_view;
  logic [31:0] rd_val;

  // The slave takes one wait cycle so that read data leaves a flip-flop.
  assign accept = hsel && htrans[1] && hready && hreadyout_ff;
  assign rd_now = dp_ff && !dp_wr_ff;
  assign wr_now = dp_ff && dp_wr_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dp_ff <= 1'b0;
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (ce) begin
      hresp_ff <= 1'b0;
      if (accept) begin
        dp_ff <= 1'b1;
        dp_wr_ff <= hwrite;
        dp_addr_ff <= {haddr[7:2], 2'b00};
        hreadyout_ff <= 1'b0;
      end else if (dp_ff) begin
        dp_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
      end
    end
  end

  assign dma_view = {seq.fifo_empty, dma_irq_status_reg};

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(dp_addr_ff, OFS_SCSI_STAT)) begin
      rd_val[SC_W-1:0] = scsi_irq_status_reg;
    end else if (hit(dp_addr_ff, OFS_DMA_STAT)) begin
      rd_val[7:0] = dma_view;
    end else if (hit(dp_addr_ff, OFS_BOTH_STAT)) begin
      rd_val[SC_W-1:0] = scsi_irq_status_reg;
      rd_val[BOTH_DMA_LSB +: 8] = dma_view;
    end else if (hit(dp_addr_ff, OFS_SUMMARY)) begin
      rd_val[SUM_SIP_BIT] = scsi_pending_flag;
      rd_val[SUM_DIP_BIT] = dma_pending_flag;
      rd_val[SUM_HALT_BIT] = seq_halted;
      rd_val[SUM_IRQ_BIT] = !irq_n_ff;
    end else if (hit(dp_addr_ff, OFS_SCSI_EN)) begin
      rd_val[SC_W-1:0] = scsi_irq_enable_reg_ff;
    end else if (hit(dp_addr_ff, OFS_DMA_EN)) begin
      rd_val[DM_W-1:0] = dma_irq_enable_reg_ff;
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ce && rd_now) begin
      hrdata_ff <= rd_val;
    end
  end

  // Reads of a status address clear that type in the same edge that latches it.
  assign s_clr = ce && rd_now && (hit(dp_addr_ff, OFS_SCSI_STAT) || hit(dp_addr_ff, OFS_BOTH_STAT));
  assign d_clr = ce && rd_now && (hit(dp_addr_ff, OFS_DMA_STAT) || hit(dp_addr_ff, OFS_BOTH_STAT));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scsi_irq_enable_reg_ff <= SCSI_EN_RST;
      dma_irq_enable_reg_ff <= DMA_EN_RST;
    end else if (ce && wr_now) begin
      if (hit(dp_addr_ff, OFS_SCSI_EN)) begin
        scsi_irq_enable_reg_ff <= hwdata[SC_W-1:0];
      end
      if (hit(dp_addr_ff, OFS_DMA_EN)) begin
        dma_irq_enable_reg_ff <= hwdata[DM_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clear_fifos_bit_ff <= 1'b0;
      flush_dma_fifo_bit_ff <= 1'b0;
    end else if (ce) begin
      clear_fifos_bit_ff <= wr_now && hit(dp_addr_ff, OFS_CTRL) && hwdata[CTL_CLF_BIT];
      flush_dma_fifo_bit_ff <= wr_now && hit(dp_addr_ff, OFS_CTRL) && hwdata[CTL_FLF_BIT];
    end
  end

  // Scsi conditions are held back while the dma fifo still has data.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_hold_ff <= '0;
    end else if (ce) begin
      s_hold_ff <= seq.fifo_empty ? '0 : (s_hold_ff | scsi_cond);
    end
  end

  assign s_post = seq.fifo_empty ? (s_hold_ff | scsi_cond) : '0;
  assign s_raise = s_post & (scsi_irq_enable_reg_ff | ~nonfatal_mask(target_mode));
  assign s_en = s_post & scsi_irq_enable_reg_ff;
  assign d_post = dma_cond;
  assign d_raise = d_post;
  assign d_en = d_post & dma_irq_enable_reg_ff;
  assign any_pend = scsi_pending_flag || dma_pending_flag;

  spiu_stack #(.W(SC_W)) u_scsi_stack (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .post(s_post),
    .raise(s_raise),
    .en_hit(s_en),
    .any_pend(any_pend),
    .rd_clr(s_clr),
    .status(scsi_irq_status_reg),
    .pend(scsi_pending_flag),
    .irqf(s_irqf),
    .stacked(s_stacked)
  );

  spiu_stack #(.W(DM_W)) u_dma_stack (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .post(d_post),
    .raise(d_raise),
    .en_hit(d_en),
    .any_pend(any_pend),
    .rd_clr(d_clr),
    .status(dma_irq_status_reg),
    .pend(dma_pending_flag),
    .irqf(d_irqf),
    .stacked(d_stacked)
  );

  // The gap gives an edge-triggered host a clean second edge.
  assign gap_start = (s_clr && s_stacked) || (d_clr && d_stacked);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gap_cnt_ff <= '0;
    end else if (ce) begin
      if (gap_start) begin
        gap_cnt_ff <= GAP_W'(GAP_CYC);
      end else if (gap_cnt_ff != '0) begin
        gap_cnt_ff <= gap_cnt_ff - 1'b1;
      end
    end
  end

  // Enable bits gate only the arrival, so masking later leaves the line down.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_n_ff <= 1'b1;
    end else if (ce) begin
      irq_n_ff <= !((s_irqf || d_irqf) && gap_cnt_ff == '0 && !gap_start);
    end
  end

  spiu_halt u_halt (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .cause((|s_raise) || (|d_raise)),
    .scsi_cause(|s_raise),
    .release_halt(!any_pend),
    .seq(seq),
    .halted(seq_halted),
    .inhibit(exec_inhibit),
    .flush_req(fifo_flush_req),
    .dsp_load(dsp_load)
  );

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign irq_n = irq_n_ff;
  assign clear_fifos = clear_fifos_bit_ff;
  assign flush_dma_fifo = flush_dma_fifo_bit_ff;

  chk_irq_gap: assert property (@(posedge clk) disable iff (!rst_b)
    ce && gap_start |=> irq_n ##1 (irq_n || !ce) [*4])
    else $error("request line did not drop for the stack gap");
  chk_mask_keep: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !irq_n && (s_irqf || d_irqf) && !s_clr && !d_clr && !gap_start |=> !irq_n)
    else $error("request line released without a status read");
  chk_masked_nonfatal: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !any_pend && s_post != '0 && s_raise == '0 && d_raise == '0 && !s_clr && !d_clr
    |=> !scsi_pending_flag && (scsi_irq_status_reg & $past(s_post)) == $past(s_post))
    else $error("masked non-fatal condition raised pending or was not posted");
  chk_fatal_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !any_pend && d_raise != '0 && d_en == '0 && !s_irqf && !d_irqf && s_en == '0
    |=> dma_pending_flag && irq_n)
    else $error("masked fatal condition mis-handled");
  chk_lockout: assert property (@(posedge clk) disable iff (!rst_b)
    !seq.fifo_empty |-> s_post == '0)
    else $error("scsi condition posted while the dma fifo holds data");
  chk_word_clear: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rd_now && hit(dp_addr_ff, OFS_BOTH_STAT) |-> s_clr && d_clr
    ##1 hrdata[BOTH_DMA_LSB +: DM_W] == $past(dma_irq_status_reg))
    else $error("word read did not return and clear both statuses");
  chk_dfe_live: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rd_now && hit(dp_addr_ff, OFS_DMA_STAT) |=> hrdata[DMA_DFE_BIT] == $past(seq.fifo_empty))
    else $error("fifo empty flag not reported live");
  chk_bus_wait: assert property (@(posedge clk) disable iff (!rst_b)
    ce && accept |=> !hreadyout ##1 (hreadyout || !ce))
    else $error("slave data phase length wrong");
endmodule : spiu_top

// *** tb/spiu_host.sv ***
// Host model: AHB-Lite master and interrupt service routine for the interrupt unit.
`timescale 1ns/1ps
module spiu_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import spiu_pkg::*;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // One single word transfer; read data is taken at the edge that ends the data phase.
  task automatic xfer(input logic [7:0] ofs, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // Word reads clear both types at once; separate status reads are still kept apart.
  task automatic service(output logic [31:0] st);
    logic [31:0] sm;
    logic [31:0] v;
    st = 32'h0000_0000;
    xfer(OFS_SUMMARY, 1'b0, 32'h0000_0000, sm);
    while (sm[1:0] != 2'b00) begin
      if (sm[1:0] == 2'b11) xfer(OFS_BOTH_STAT, 1'b0, 32'h0000_0000, v);
      else if (sm[SUM_SIP_BIT]) xfer(OFS_SCSI_STAT, 1'b0, 32'h0000_0000, v);
      else xfer(OFS_DMA_STAT, 1'b0, 32'h0000_0000, v);
      st = st | v;
      // A clearing read needs time to settle before the next status read follows.
      repeat (HOST_BYTE_GAP_CLK) @(posedge clk);
      xfer(OFS_SUMMARY, 1'b0, 32'h0000_0000, sm);
    end
  endtask : service
endmodule : spiu_host

// *** tb/spiu_top_test.sv ***
// Self-checking bench for the interrupt unit driven through the host model.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, got, exp); end end
module spiu_top_test;
  import spiu_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [SC_W-1:0] scsi_cond = '0;
  logic [DM_W-1:0] dma_cond = '0;
  logic target_mode = 1'b0;
  logic ce = 1'b1;
  spiu_seq_s seq = 8'h01;
  logic hsel, hwrite, hreadyout, hresp, irq_n, seq_halted, exec_inhibit, fifo_flush_req, dsp_load;
  logic clear_fifos, flush_dma_fifo;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n_dsp = 0;
  int n_clf = 0;
  int n_flf = 0;
  always #10 clk = ~clk;
  spiu_top i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scsi_cond(scsi_cond), .dma_cond(dma_cond), .target_mode(target_mode), .seq(seq),
    .irq_n(irq_n), .seq_halted(seq_halted), .exec_inhibit(exec_inhibit), .fifo_flush_req(fifo_flush_req),
    .dsp_load(dsp_load), .clear_fifos(clear_fifos), .flush_dma_fifo(flush_dma_fifo));
  spiu_host i_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  always @(posedge clk) begin
    cyc++;
    if (dsp_load === 1'b1) n_dsp++;
    if (clear_fifos === 1'b1) n_clf++;
    if (flush_dma_fifo === 1'b1) n_flf++;
    // The whole run needs a few hundred cycles; a hang ends here.
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task wr(input logic [7:0] a, input logic [31:0] v);
    i_host.xfer(a, 1'b1, v, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(a, 1'b0, 32'h0000_0000, d);
    `CHK(d, e)
  endtask : rdc
  // Conditions are one-cycle pulses; the wait lets status, pending and request settle.
  task pulse(input logic [SC_W-1:0] s, input logic [DM_W-1:0] m);
    @(posedge clk);
    scsi_cond <= s;
    dma_cond <= m;
    @(posedge clk);
    scsi_cond <= '0;
    dma_cond <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task t_basic();
    `CHK(irq_n, 1'b1)
    rdc(OFS_SCSI_EN, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    `CHK(hresp, 1'b0)
  endtask : t_basic
  task t_nonfatal();
    wr(OFS_SCSI_EN, 32'h0000_0008);
    pulse(8'h01, '0);
    `CHK(irq_n, 1'b1)
    rdc(OFS_SUMMARY, 32'h0000_0000);
    pulse(8'h08, '0);
    `CHK(irq_n, 1'b0)
    rdc(OFS_SCSI_STAT, 32'h0000_0009);
    rdc(OFS_SUMMARY, 32'h0000_0000);
    target_mode <= 1'b1;
    pulse(8'h04, '0);
    rdc(OFS_SUMMARY, 32'h0000_0000);
    target_mode <= 1'b0;
    pulse(8'h04, '0);
    rdc(OFS_SUMMARY, 32'h0000_0005);
    rdc(OFS_SCSI_STAT, 32'h0000_0004);
  endtask : t_nonfatal
  task t_fatal();
    pulse('0, 7'h01);
    `CHK(irq_n, 1'b1)
    rdc(OFS_SUMMARY, 32'h0000_0006);
    rdc(OFS_DMA_STAT, 32'h0000_0081);
    rdc(OFS_DMA_STAT, 32'h0000_0080);
  endtask : t_fatal
  task t_stack();
    int n;
    wr(OFS_SCSI_EN, 32'h0000_00F8);
    pulse(8'h08, '0);
    wr(OFS_SCSI_EN, 32'h0000_0000);
    `CHK(irq_n, 1'b0)
    wr(OFS_SCSI_EN, 32'h0000_00F8);
    pulse(8'h10, '0);
    pulse(8'h20, '0);
    rdc(OFS_SCSI_STAT, 32'h0000_0008);
    n = 0;
    while (irq_n === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK((n >= GAP_CYC) && (n <= GAP_CYC + 2), 1'b1)
    `CHK(irq_n, 1'b0)
    rdc(OFS_SCSI_STAT, 32'h0000_0030);
    repeat (2) @(posedge clk);
    `CHK(irq_n, 1'b1)
  endtask : t_stack
  task t_simul();
    wr(OFS_DMA_EN, 32'h0000_007F);
    rdc(OFS_DMA_EN, 32'h0000_007F);
    pulse(8'h18, 7'h05);
    rdc(OFS_SUMMARY, 32'h0000_000F);
    i_host.xfer(OFS_BOTH_STAT, 1'b0, 32'h0000_0000, d);
    `CHK(d, 32'h0000_8518)
    rdc(OFS_SUMMARY, 32'h0000_0000);
  endtask : t_simul
  task t_lock();
    @(posedge clk);
    seq <= 8'h00;
    pulse('0, 7'h02);
    `CHK(fifo_flush_req, 1'b0)
    `CHK(n_flf, 0)
    rdc(OFS_DMA_STAT, 32'h0000_0002);
    pulse(8'h08, '0);
    rdc(OFS_SUMMARY, 32'h0000_0000);
    seq <= 8'h01;
    repeat (3) @(posedge clk);
    rdc(OFS_SUMMARY, 32'h0000_000D);
    rdc(OFS_SCSI_STAT, 32'h0000_0008);
  endtask : t_lock
  task t_halt();
    logic [7:0] busy [4] = '{8'h81, 8'h21, 8'h11, 8'h0D};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      seq <= busy[i];
      pulse('0, 7'h01);
      `CHK(exec_inhibit, 1'b1)
      `CHK(seq_halted, 1'b0)
      seq <= (busy[i] & 8'h05) | 8'h01;
      repeat (3) @(posedge clk);
      `CHK(seq_halted, 1'b1)
      i_host.service(d);
      seq <= 8'h01;
    end
    seq <= 8'hC1;
    pulse('0, 7'h01);
    `CHK(seq_halted, 1'b1)
    i_host.service(d);
    seq <= 8'h01;
    `CHK(n_dsp, 1)
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0002);
    // The pulse counters run at the same edge as the task returns; let one edge pass.
    @(posedge clk);
    `CHK(n_clf, 1)
    `CHK(n_flf, 1)
    // A scsi cause toward memory with data left in the fifo drains before halting.
    seq <= 8'h0B;
    pulse(8'h08, '0);
    seq <= 8'h02;
    repeat (2) @(posedge clk);
    `CHK(fifo_flush_req, 1'b1)
    `CHK(seq_halted, 1'b0)
    seq <= 8'h03;
    repeat (3) @(posedge clk);
    `CHK(fifo_flush_req, 1'b0)
    `CHK(seq_halted, 1'b1)
    i_host.service(d);
    seq <= 8'h01;
  endtask : t_halt
  // With the clock enable low nothing is captured, so a pulse then is lost.
  task t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    pulse(8'h08, 7'h01);
    `CHK(irq_n, 1'b1)
    ce <= 1'b1;
    rdc(OFS_SUMMARY, 32'h0000_0000);
  endtask : t_freeze
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_basic();
    t_nonfatal();
    t_fatal();
    t_stack();
    t_simul();
    t_lock();
    t_halt();
    t_freeze();
    give_verdict();
  end
endmodule : spiu_top_test
